// file: verilog/rgs_scaler.sv
/*
  reference gear scaler: turns reference units into encoder counts
  by the ratio numerator/denominator, carrying the remainder.
  assumes the host writes parameters over the link port, keeps the
  ratio in range and in lowest terms, and that inputs are synchronous.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rgs_consts.svh"

module rgs_scaler
  import rgs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        param_wr_i,
  input  wire logic        param_sel_i,
  input  wire logic [15:0] param_wdata_i,
  output logic      [15:0] param_rdata_o,
  output logic             param_err_o,
  input  wire logic [1:0]  enc_type_i,
  input  wire logic        ref_valid_i,
  input  wire logic [15:0] ref_units_i,
  output logic             ref_ready_o,
  output logic             out_valid_o,
  output logic [31:0]      motor_counts_o,
  output logic [31:0]      position_o,
  output logic [17:0]      quad_pulses_o
);
  rgs_param_type gear_numerator_param;
  rgs_param_type gear_denominator_param;
  rgs_param_type residue;
  rgs_state_type state;
  logic [47:0]   product;
  logic          start_q;
  logic          err_q;
  rgs_div_if     div ();

  // encoder pulse count by type, before the x4 quadrature shift
  function automatic logic [16:0] rgs_pulses(input logic [1:0] t);
    logic [16:0] p;
    p = `RGS_PULSES_17B;
    unique case (t)
      `RGS_ENC_13B: p = `RGS_PULSES_13B;
      `RGS_ENC_16B: p = `RGS_PULSES_16B;
      default:      p = `RGS_PULSES_17B;
    endcase
    return p;
  endfunction

  // ==========================================================
  // gear parameters
  // zero is out of range: refused, value kept, error flagged
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gear_numerator_param   <= `RGS_NUM_RESET;
      gear_denominator_param <= `RGS_DEN_RESET;
      err_q                  <= 1'b0;
    end else if (param_wr_i) begin
      err_q <= (param_wdata_i < `RGS_PARAM_MIN);
      if (param_wdata_i >= `RGS_PARAM_MIN) begin
        if (param_sel_i == `RGS_SEL_NUM) begin
          gear_numerator_param <= param_wdata_i;
        end else begin
          gear_denominator_param <= param_wdata_i;
        end
      end
    end
  end

  assign param_err_o = err_q;

  // ==========================================================
  // parameter read-back, registered one cycle behind the select
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      param_rdata_o <= `RGS_NUM_RESET;
    end else if (param_sel_i == `RGS_SEL_NUM) begin
      param_rdata_o <= gear_numerator_param;
    end else begin
      param_rdata_o <= gear_denominator_param;
    end
  end

  // quadrature pulse count, registered; 17-bit type needs 18 bits after x4
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      quad_pulses_o <= {1'b0, `RGS_PULSES_13B} << `RGS_QUAD_SHIFT;
    end else begin
      quad_pulses_o <= {1'b0, rgs_pulses(enc_type_i)} << `RGS_QUAD_SHIFT;
    end
  end

  // ==========================================================
  // scaling sequence: multiply, divide with carried residue
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state          <= RGS_IDLE;
      product        <= 48'h0;
      start_q        <= 1'b0;
      residue        <= 16'h0;
      out_valid_o    <= 1'b0;
      motor_counts_o <= 32'h0;
      position_o     <= 32'h0;
    end else begin
      start_q     <= 1'b0;
      out_valid_o <= 1'b0;
      unique case (state)
        RGS_IDLE: begin
          if (ref_valid_i) begin
            // each unit is one reference pulse
            product <= {32'h0, ref_units_i} * {32'h0, gear_numerator_param} + {32'h0, residue};
            state   <= RGS_MULT;
          end
        end
        RGS_MULT: begin
          start_q <= 1'b1;
          state   <= RGS_DIV;
        end
        RGS_DIV: begin
          if (div.done) begin
            residue        <= div.remainder;
            motor_counts_o <= div.quotient[31:0];
            position_o     <= position_o + div.quotient[31:0];
            out_valid_o    <= 1'b1;
            state          <= RGS_IDLE;
          end
        end
      endcase
    end
  end

  assign ref_ready_o  = (state == RGS_IDLE);
  assign div.start    = start_q;
  assign div.dividend = product;
  assign div.divisor  = gear_denominator_param;

  rgs_divider u_div (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .div    (div)
  );

  // ==========================================================
  // checks
  sequence s_take;
    ref_valid_i && ref_ready_o;
  endsequence

  sequence s_done;
    ##[50:53] out_valid_o;
  endsequence

  // result strobe seen exactly at the edge after the divider's done
  sequence s_answer;
    ##52 out_valid_o;
  endsequence

  scale_latency_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_take |-> s_done) else $error("scaled output not produced in time");

  busy_refuse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_take |=> !ref_ready_o [*8]) else $error("accepted reference while busy");

  residue_bound_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    out_valid_o |-> residue < gear_denominator_param) else $error("residue not below denominator");

  pos_accum_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    out_valid_o |-> position_o == $past(position_o) + motor_counts_o) else $error("position not accumulated");

  num_nonzero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    gear_numerator_param != 16'h0) else $error("numerator left range");

  den_nonzero_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    gear_denominator_param != 16'h0) else $error("denominator left range");

  num_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    param_wr_i && !param_sel_i && param_wdata_i != 16'h0 |=> gear_numerator_param == $past(param_wdata_i))
    else $error("numerator write lost");

  den_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    param_wr_i && param_sel_i && param_wdata_i != 16'h0 |=> gear_denominator_param == $past(param_wdata_i))
    else $error("denominator write lost");

  zero_refuse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    param_wr_i && param_wdata_i == 16'h0 |=> param_err_o && $stable(gear_numerator_param)
    && $stable(gear_denominator_param)) else $error("zero write not refused");

  quad_scale_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    enc_type_i == `RGS_ENC_13B |=> quad_pulses_o == 18'h02000) else $error("13-bit quad count wrong");

  answer_time_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_take |-> s_answer) else $error("scaled output not at its fixed latency");

  start_pulse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_take |-> ##2 div.start) else $error("divider not started after take");

  ready_return_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    out_valid_o |-> ref_ready_o) else $error("not ready with the result");

  counts_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !out_valid_o |-> $stable(motor_counts_o) && $stable(position_o)) else $error("counts moved without result");

  residue_carry_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    out_valid_o |-> residue == $past(div.remainder) && {16'h0, motor_counts_o} == $past(div.quotient))
    else $error("quotient or remainder not carried");

  err_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    param_wr_i && param_wdata_i != 16'h0 |=> !param_err_o) else $error("error flag kept after valid write");

  num_readback_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    param_sel_i == `RGS_SEL_NUM |=> param_rdata_o == $past(gear_numerator_param))
    else $error("numerator read-back wrong");

  den_readback_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    param_sel_i == `RGS_SEL_DEN |=> param_rdata_o == $past(gear_denominator_param))
    else $error("denominator read-back wrong");
endmodule
`default_nettype wire

// file: include/rgs_consts.svh
/*
  constants for the reference gear scaler: parameter reset values,
  parameter select codes, encoder resolutions and widths.
  assumes it is included by its bare name from design files.
*/
`ifndef RGS_CONSTS_SVH
`define RGS_CONSTS_SVH

`define RGS_NUM_RESET   16'h0004
`define RGS_DEN_RESET   16'h0001
`define RGS_PARAM_MIN   16'h0001
`define RGS_SEL_NUM     1'h0
`define RGS_SEL_DEN     1'h1
`define RGS_PULSES_13B  17'h00800
`define RGS_PULSES_16B  17'h04000
`define RGS_PULSES_17B  17'h08000
`define RGS_QUAD_SHIFT  2
`define RGS_DIV_STEPS   6'h30
`define RGS_ENC_13B     2'h0
`define RGS_ENC_16B     2'h1
`define RGS_ENC_17B     2'h2

`endif

// file: include/rgs_pkg.sv
/*
  types for the reference gear scaler.
  assumes rgs_consts.svh is available on the include path.
*/
package rgs_pkg;
  typedef logic [15:0] rgs_param_type;
  typedef logic [31:0] rgs_count_type;
  typedef enum logic [2:0] {
    RGS_IDLE = 3'h1,
    RGS_MULT = 3'h2,
    RGS_DIV  = 3'h4
  } rgs_state_type;
endpackage

// file: include/rgs_div_if.sv
/*
  interface between the gear scaler and its divider.
  assumes a single clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface rgs_div_if;
  import rgs_pkg::*;
  logic          start;
  logic [47:0]   dividend;
  rgs_param_type divisor;
  logic          done;
  logic [47:0]   quotient;
  rgs_param_type remainder;
  modport master (output start, output dividend, output divisor,
                  input done, input quotient, input remainder);
  modport slave  (input start, input dividend, input divisor,
                  output done, output quotient, output remainder);
endinterface
`default_nettype wire

// file: verilog/rgs_divider.sv
/*
  restoring serial divider, one quotient bit per clock.
  assumes the divisor is non-zero and start is held off while busy.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rgs_consts.svh"
module rgs_divider
  import rgs_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  rgs_div_if.slave    div
);
  logic [47:0] quo;
  logic [16:0] rem;
  logic [5:0]  cnt;
  logic        busy;
  logic [16:0] trial;
  logic        done_q;

  // ==========================================================
  // shift-subtract step
  assign trial = {rem[15:0], quo[47]};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      quo    <= 48'h0;
      rem    <= 17'h0;
      cnt    <= 6'h0;
      busy   <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (div.start && !busy) begin
        quo  <= div.dividend;
        rem  <= 17'h0;
        cnt  <= `RGS_DIV_STEPS;  // one step per dividend bit
        busy <= 1'b1;
      end else if (busy) begin
        if (trial >= {1'b0, div.divisor}) begin
          rem <= trial - {1'b0, div.divisor};
          quo <= {quo[46:0], 1'b1};
        end else begin
          rem <= trial;
          quo <= {quo[46:0], 1'b0};
        end
        cnt <= cnt - 6'h1;
        if (cnt == 6'h1) begin
          busy   <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign div.done      = done_q;
  assign div.quotient  = quo;
  assign div.remainder = rem[15:0];
endmodule
`default_nettype wire

// file: bench/rgs_host_model.sv
/*
  host model: writes gear parameters over the link and issues references.
  assumes clk_i at 100 MHz; it changes its outputs only at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module rgs_host_model (
  input  wire logic   clk_i,
  output logic        param_wr_o,
  output logic        param_sel_o,
  output logic [15:0] param_wdata_o,
  output logic        ref_valid_o,
  output logic [15:0] ref_units_o,
  input  wire logic   ref_ready_i,
  input  wire logic   out_valid_i
);
  // ====================
  // idle levels
  initial begin
    param_wr_o = 1'b0;
    param_sel_o = 1'b0;
    param_wdata_o = 16'h5a5a;
    ref_valid_o = 1'b0;
    ref_units_o = 16'ha5a5;
  end

  // one-cycle link write; value passed unchecked, caller may write zero or an unreduced ratio
  task automatic wr(input logic s, input logic [15:0] d);
    param_sel_o = s;
    param_wdata_o = d;
    param_wr_o = 1'b1;
    @(negedge clk_i);
    param_wr_o = 1'b0;
    param_wdata_o = ~d; // no stale data once released
  endtask

  // one reference; keep leaves valid up so the next one follows at once
  task automatic send(input logic [15:0] u, input bit keep, output int lat);
    ref_units_o = u;
    ref_valid_o = 1'b1;
    while (ref_ready_i !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    if (!keep) begin
      ref_valid_o = 1'b0;
      ref_units_o = ~u;
    end
    lat = 0;
    while (out_valid_i !== 1'b1 && lat < 300) begin
      @(negedge clk_i);
      lat++;
    end
  endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
/*
  self-checking bench for the gear scaler: by hand reset values and a refused
  write, then a table of ratios, then back-to-back references.
  assumes rgs_pkg is compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench
  import rgs_pkg::*;
;
  typedef struct packed {logic [1:0] enc; logic [15:0] num; logic [15:0] den; logic [15:0] units;} rgs_row_type;
  logic clk_i, rstn_i, param_wr_i, param_sel_i, param_err_o, ref_valid_i, ref_ready_o, out_valid_o;
  logic [15:0]   param_wdata_i, param_rdata_o, ref_units_i;
  logic [1:0]    enc_type_i;
  rgs_count_type motor_counts_o, position_o;
  logic [17:0]   quad_pulses_o;
  int            failures, n_checks;
  longint        num, den, res, pos;
  rgs_row_type   rows [0:5] = '{'{2'h0, 16'h0004, 16'h0001, 16'h0064}, '{2'h1, 16'h2000, 16'h1770, 16'h0007},
    '{2'h2, 16'h6000, 16'h0e10, 16'h0005}, '{2'h3, 16'hc000, 16'hf172, 16'hffff},
    '{2'h0, 16'h0001, 16'h0064, 16'h0001}, '{2'h1, 16'h0064, 16'h0001, 16'hffff}};

  rgs_scaler dut (.clk_i, .rstn_i, .param_wr_i, .param_sel_i, .param_wdata_i, .param_rdata_o, .param_err_o,
    .enc_type_i, .ref_valid_i, .ref_units_i, .ref_ready_o, .out_valid_o, .motor_counts_o, .position_o,
    .quad_pulses_o);
  rgs_host_model host (.clk_i, .param_wr_o(param_wr_i), .param_sel_o(param_sel_i), .param_wdata_o(param_wdata_i),
    .ref_valid_o(ref_valid_i), .ref_units_o(ref_units_i), .ref_ready_i(ref_ready_o), .out_valid_i(out_valid_o));

  // ====================
  // compare and closing
  task automatic chk_val(input rgs_count_type got, input rgs_count_type exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ====================
  // ratio writes and reference runs against a remainder-carrying model
  task automatic setr(input logic [15:0] n, input logic [15:0] d);
    host.wr(1'b0, n);
    @(negedge clk_i);
    chk_val(32'(param_rdata_o), 32'(n));
    host.wr(1'b1, d);
    @(negedge clk_i);
    chk_val(32'(param_rdata_o), 32'(d));
    num = n;
    den = d;
  endtask
  task automatic run(input logic [15:0] u, input bit keep);
    int     lat;
    longint t;
    host.send(u, keep, lat);
    t = longint'(u) * num + res;
    res = t % den;
    pos += t / den;
    chk_val(32'(lat), 32'h0000_0033);
    chk_val(motor_counts_o, 32'(t / den));
    chk_val(position_o, 32'(pos));
  endtask

  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #300000;
    failures++;
    results();
  end

  // main sequence
  initial begin
    rstn_i = 1'b0;
    enc_type_i = 2'h0;
    res = 0;
    pos = 0;
    repeat (8) @(negedge clk_i);
    rstn_i = 1'b1;
    chk_val(32'(param_rdata_o), 32'h0000_0004);
    chk_bit(ref_ready_o, 1'b1);
    host.wr(1'b1, 16'h0000);
    chk_val(32'(param_rdata_o), 32'h0000_0001);
    chk_bit(param_err_o, 1'b1);
    num = 4;
    den = 1;
    run(16'h0003, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      enc_type_i = rows[i].enc;
      setr(rows[i].num, rows[i].den);
      chk_bit(param_err_o, 1'b0);
      run(rows[i].units, 1'b0);
      chk_val(32'(quad_pulses_o), rows[i].enc == 2'h0 ? 32'h2000 : rows[i].enc == 2'h1 ? 32'h10000 : 32'h20000);
      $display("test row %0d done", i);
    end
    setr(16'h0001, 16'h0003);
    run(16'h0001, 1'b1);
    run(16'h0001, 1'b1);
    run(16'h0001, 1'b0);
    $display("test back to back done");
    results();
  end
endmodule
`default_nettype wire
